// ==== bws_pkg.sv ====
package bws_pkg;

    localparam int BWS_BURST_LEN  = 4;
    localparam int BWS_OFS_W      = 2;
    localparam int BWS_LANE_W     = 9;
    localparam int BWS_NIB_W      = 4;
    localparam int BWS_ORG_X8     = 8;
    localparam int BWS_ORG_X9     = 9;
    localparam int BWS_ORG_X18    = 18;
    localparam int BWS_ORG_X36    = 36;
    localparam int BWS_NUM_EN     = 4;
    localparam int BWS_ADDR_W     = 8;
    localparam int BWS_DATA_W     = 36;
    localparam logic [1:0] BWS_OFS_LAST = 2'h3;

    typedef enum logic [1:0] {
        BWS_IDLE  = 2'b00,
        BWS_BEAT0 = 2'b01,
        BWS_BEAT1 = 2'b10
    } bws_state_type;

    // Lane write mask, one bit per data bit, from the active-low lane enables
    function automatic logic [BWS_DATA_W-1:0] bws_lane_mask(
        input int                     org,
        input logic [BWS_NUM_EN-1:0]  en_n
    );
        logic [BWS_DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < BWS_DATA_W; i++) begin
            if (org == BWS_ORG_X8) begin
                if (i < BWS_ORG_X8) m[i] = ~en_n[i / BWS_NIB_W];
            end else if (org == BWS_ORG_X9) begin
                if (i < BWS_ORG_X9) m[i] = ~en_n[0];
            end else if (org == BWS_ORG_X18) begin
                if (i < BWS_ORG_X18) m[i] = ~en_n[i / BWS_LANE_W];
            end else begin
                m[i] = ~en_n[i / BWS_LANE_W];
            end
        end
        return m;
    endfunction : bws_lane_mask

endpackage : bws_pkg

// ==== bws_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Both K and K# rising edges are modelled as mclk cycles: beat on K (first) then K# (second)
interface bws_link_if
    import bws_pkg::*;
#(
    parameter int AW = BWS_ADDR_W,
    parameter int DW = BWS_DATA_W
);
    logic                  rd_sel_n;
    logic                  wr_sel_n;
    logic [AW-1:0]         addr;
    logic [DW-1:0]         wdata;
    logic [BWS_NUM_EN-1:0] lane_en_n;
    logic [DW-1:0]         rdata;
    logic                  rdata_oe;

    modport ctrl (output rd_sel_n, output wr_sel_n, output addr, output wdata,
                  output lane_en_n, input rdata, input rdata_oe);
    modport mem  (input rd_sel_n, input wr_sel_n, input addr, input wdata,
                  input lane_en_n, output rdata, output rdata_oe);
endinterface : bws_link_if
`default_nettype wire

// ==== bws_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Controller end: issues one burst per request, spacing enforced here
module bws_ctrl
    import bws_pkg::*;
#(
    parameter int AW = BWS_ADDR_W,
    parameter int DW = BWS_DATA_W
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    bws_link_if.ctrl                   link,
    input  wire logic                  wr_req,
    input  wire logic                  rd_req,
    input  wire logic [AW-1:0]         req_addr,
    input  wire logic [4*DW-1:0]       req_wdata,
    input  wire logic [4*BWS_NUM_EN-1:0] req_en_n,
    output logic                       wr_taken,
    output logic                       rd_taken,
    output logic                       busy
);
    // Each K cycle has two beats; phase_q 0 = K edge, 1 = K# edge
    // Selects launch on the K# edge so they stand when the far end samples at K
    logic                    phase_q;
    logic [1:0]              wbeat_q;
    logic                    wact_q;
    logic                    rlast_q;
    logic                    wlast_q;
    logic [4*DW-1:0]         wd_q;
    logic [4*BWS_NUM_EN-1:0] en_q;
    logic                    go_rd;
    logic                    go_wr;

    // Requests taken only on K# edges (phase_q 1) and never back to back of the same kind
    assign go_rd = phase_q && rd_req && !rlast_q;
    assign go_wr = phase_q && wr_req && !rd_req && !wlast_q && !wact_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            link.rd_sel_n <= 1'b1;
            link.wr_sel_n <= 1'b1;
            link.addr     <= '0;
            rlast_q       <= 1'b0;
            wlast_q       <= 1'b0;
            rd_taken      <= 1'b0;
            wr_taken      <= 1'b0;
        end else begin
            rd_taken <= go_rd;
            wr_taken <= go_wr;
            if (phase_q) begin
                link.rd_sel_n <= ~go_rd;
                link.wr_sel_n <= ~go_wr;
                rlast_q       <= go_rd;
                wlast_q       <= go_wr;
                if (go_rd || go_wr) link.addr <= req_addr;
            end else begin
                link.rd_sel_n <= 1'b1;
                link.wr_sel_n <= 1'b1;
            end
        end
    end

    // Write data beats follow the select on the next two K cycles
    always_ff @(posedge mclk) begin
        if (rst) begin
            wact_q         <= 1'b0;
            wbeat_q        <= '0;
            wd_q           <= '0;
            en_q           <= '1;
            link.wdata     <= '0;
            link.lane_en_n <= '1;
            busy           <= 1'b0;
        end else begin
            busy <= wact_q || go_wr || go_rd;
            if (go_wr) begin
                wd_q    <= req_wdata;
                en_q    <= req_en_n;
                wact_q  <= 1'b1;
                wbeat_q <= '0;
            end
            if (wact_q && (wbeat_q != 2'h0 || phase_q)) begin
                link.wdata     <= wd_q[wbeat_q*DW +: DW];
                link.lane_en_n <= en_q[wbeat_q*BWS_NUM_EN +: BWS_NUM_EN];
                wbeat_q        <= wbeat_q + 2'h1;
                if (wbeat_q == BWS_OFS_LAST) wact_q <= 1'b0;
            end else begin
                link.lane_en_n <= '1;
            end
        end
    end
endmodule : bws_ctrl
`default_nettype wire

// ==== bws_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - x8: two nibble enables gate bits 0-3, 4-7
// - x9: one enable gates all nine bits
// - x18: two enables gate lanes 0-8, 9-17
// - x36: four enables gate four nine-bit lanes
// - Enables sampled on every beat separately
// - Enables act only inside initiated write bursts
// - Burst address gains two internal low bits
// - Offsets step 0,1,2,3 for reads, writes
// - Burst ends after four words
// - Read and write machines run independently
// - Read wins when both selects asserted
// - Only K edges start bursts; beats step on both K and K# edges
// - Write data beats on next two K cycles
// - Read words delivered starting following cycle
// - Same-kind request on consecutive K ignored
// - Controls registered on K; idle keeps outputs off
module bws_mem
    import bws_pkg::*;
#(
    parameter int AW  = BWS_ADDR_W,
    parameter int DW  = BWS_DATA_W,
    parameter int ORG = BWS_ORG_X36
) (
    bws_link_if.mem       link,
    input  wire logic     mclk,
    input  wire logic     rst,
    output logic          wr_busy,
    output logic          rd_busy
);
    localparam int DEPTH = (1 << AW) * BWS_BURST_LEN;

    // Storage array, one word per burst offset
    logic [DW-1:0]           mem_q [DEPTH];
    logic                    phase_q;
    bws_state_type           wst_q;
    bws_state_type           rst_q;
    logic [AW-1:0]           waddr_q;
    logic [AW-1:0]           raddr_q;
    logic [BWS_OFS_W-1:0]    wofs_q;
    logic [BWS_OFS_W-1:0]    rofs_q;
    logic                    rd_prev_q;
    logic                    wr_prev_q;
    logic                    start_rd;
    logic                    start_wr;
    logic [AW+BWS_OFS_W-1:0] widx;
    logic [AW+BWS_OFS_W-1:0] ridx;
    logic [DW-1:0]           mask;

    // Commands seen only on K edges (phase 0)
    assign start_rd = !phase_q && !link.rd_sel_n && !rd_prev_q;
    assign start_wr = !phase_q && !link.wr_sel_n && link.rd_sel_n && !wr_prev_q;
    assign widx     = {waddr_q, wofs_q};
    assign ridx     = {raddr_q, rofs_q};
    assign mask     = bws_lane_mask(ORG, link.lane_en_n);

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    // Consecutive-edge filter works on raw selects, per the ignore behaviour
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end else if (!phase_q) begin
            rd_prev_q <= ~link.rd_sel_n;
            wr_prev_q <= ~link.wr_sel_n;
        end
    end

    // Write machine: BEAT0 waits for K(t+1), then four beats
    always_ff @(posedge mclk) begin
        if (rst) begin
            wst_q   <= BWS_IDLE;
            waddr_q <= '0;
            wofs_q  <= '0;
            wr_busy <= 1'b0;
        end else begin
            case (wst_q)
                BWS_IDLE: begin
                    if (start_wr) begin
                        wst_q   <= BWS_BEAT0;
                        waddr_q <= link.addr;
                        wofs_q  <= '0;
                        wr_busy <= 1'b1;
                    end
                end
                BWS_BEAT0: begin
                    wst_q <= BWS_BEAT1;
                end
                BWS_BEAT1: begin
                    wofs_q <= wofs_q + 2'h1;
                    if (wofs_q == BWS_OFS_LAST) begin
                        wst_q   <= BWS_IDLE;
                        wr_busy <= 1'b0;
                    end
                end
                default: wst_q <= BWS_IDLE;
            endcase
        end
    end

    // Masked write; lanes with enable high keep their old bits
    always_ff @(posedge mclk) begin
        if (wst_q == BWS_BEAT1) begin
            mem_q[widx] <= (mem_q[widx] & ~mask) | (link.wdata & mask);
        end
    end

    // Read machine, independent of the write one
    always_ff @(posedge mclk) begin
        if (rst) begin
            rst_q         <= BWS_IDLE;
            raddr_q       <= '0;
            rofs_q        <= '0;
            rd_busy       <= 1'b0;
            link.rdata    <= '0;
            link.rdata_oe <= 1'b0;
        end else begin
            case (rst_q)
                BWS_IDLE: begin
                    link.rdata_oe <= 1'b0;
                    if (start_rd) begin
                        rst_q   <= BWS_BEAT1;
                        raddr_q <= link.addr;
                        rofs_q  <= '0;
                        rd_busy <= 1'b1;
                    end
                end
                BWS_BEAT1: begin
                    link.rdata    <= mem_q[ridx];
                    link.rdata_oe <= 1'b1;
                    rofs_q        <= rofs_q + 2'h1;
                    // A read two K cycles later lands on the last word: chain it
                    if (rofs_q == BWS_OFS_LAST) begin
                        if (start_rd) begin
                            raddr_q <= link.addr;
                        end else begin
                            rst_q   <= BWS_IDLE;
                            rd_busy <= 1'b0;
                        end
                    end
                end
                default: rst_q <= BWS_IDLE;
            endcase
        end
    end
endmodule : bws_mem
`default_nettype wire

// ==== bws_link_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module bws_link_checker
    import bws_pkg::*;
#(
    parameter int AW = BWS_ADDR_W,
    parameter int DW = BWS_DATA_W
) (
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire logic                  rd_sel_n,
    input wire logic                  wr_sel_n,
    input wire logic [AW-1:0]         addr,
    input wire logic [DW-1:0]         wdata,
    input wire logic [BWS_NUM_EN-1:0] lane_en_n,
    input wire logic [DW-1:0]         rdata,
    input wire logic                  rdata_oe
);
    // Low on K edges, high on K# edges
    logic k_phase_q;
    always_ff @(posedge mclk) begin
        if (rst) k_phase_q <= 1'b0;
        else k_phase_q <= ~k_phase_q;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_RD_GAP: assert property (!rd_sel_n |=> rd_sel_n [*3])
        else $error("read select on consecutive K edges");
    AST_WR_GAP: assert property (!wr_sel_n |=> wr_sel_n [*3])
        else $error("write select on consecutive K edges");
    AST_RD_ON_K: assert property (!rd_sel_n |-> !k_phase_q)
        else $error("read select seen on a K# edge");
    AST_WR_ON_K: assert property (!wr_sel_n |-> !k_phase_q)
        else $error("write select seen on a K# edge");
    // Enables may only move in the four beats that follow a write select
    AST_LANE_WIN: assert property (lane_en_n != 4'hf |-> !$past(wr_sel_n, 2)
        || !$past(wr_sel_n, 3) || !$past(wr_sel_n, 4) || !$past(wr_sel_n, 5))
        else $error("lane enables active outside a write burst");
    AST_OE_LEN: assert property (!rd_sel_n |-> ##[1:2] rdata_oe [*4])
        else $error("read burst not four words long");
    AST_OE_CAUSE: assert property ($rose(rdata_oe) |->
        !$past(rd_sel_n) || !$past(rd_sel_n, 2))
        else $error("read data driven without a read");
    AST_OE_END: assert property ($fell(rdata_oe) |-> $past(rdata_oe, 2)
        && $past(rdata_oe, 3) && $past(rdata_oe, 4))
        else $error("read burst ended before four words");
    COV_WR: cover property (!wr_sel_n);
    COV_RD: cover property (!rd_sel_n);
    COV_OVERLAP: cover property (rdata_oe && lane_en_n != 4'hf);
endmodule : bws_link_checker
`default_nettype wire

// ==== burst4_byte_write_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module burst4_byte_write_sequencer_tb;
    import bws_pkg::*;
    logic        mclk, rst, wr_req, rd_req, wr_taken, rd_taken, busy, wr_busy, rd_busy;
    logic [7:0]  req_addr, tag;
    logic [143:0] req_wdata;
    logic [15:0] req_en_n;
    logic [35:0] mdl [0:1023];
    int          err_total, cmp_count, cyc;

    bws_link_if lnk ();
    bws_ctrl i_bws_ctrl (.mclk(mclk), .rst(rst), .link(lnk), .wr_req(wr_req), .rd_req(rd_req),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_en_n(req_en_n),
        .wr_taken(wr_taken), .rd_taken(rd_taken), .busy(busy));
    bws_mem #(.ORG(BWS_ORG_X36)) i_bws_mem (.link(lnk), .mclk(mclk), .rst(rst),
        .wr_busy(wr_busy), .rd_busy(rd_busy));
    bws_link_checker i_bws_link_checker (.mclk(mclk), .rst(rst), .rd_sel_n(lnk.rd_sel_n),
        .wr_sel_n(lnk.wr_sel_n), .addr(lnk.addr), .wdata(lnk.wdata),
        .lane_en_n(lnk.lane_en_n), .rdata(lnk.rdata), .rdata_oe(lnk.rdata_oe));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Ceiling sized well above the sequence below, so only a hang reaches it
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("Compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    // Model updated at hand-off; reads of the same address wait for idle first
    task automatic do_wr(input logic [7:0] a, input logic [15:0] en);
        logic [35:0] m, d;
        int n;
        n = 0;
        req_addr = a;
        req_en_n = en;
        for (int k = 0; k < 4; k++) req_wdata[k*36+:36] = {tag[3:0], a, 8'(k), tag, ~tag};
        wr_req = 1'b1;
        // Step past any taken pulse still showing from the call before
        do begin
            @(negedge mclk);
            n++;
        end while (wr_taken !== 1'b1 && n < 20);
        wr_req = 1'b0;
        `CHK(wr_taken, 1'b1)
        for (int k = 0; k < 4; k++) begin
            m = '0;
            for (int j = 0; j < 4; j++) if (!en[k*4+j]) m[j*9+:9] = 9'h1ff;
            d = req_wdata[k*36+:36];
            mdl[{a, 2'(k)}] = (mdl[{a, 2'(k)}] & ~m) | (d & m);
        end
        tag++;
    endtask : do_wr

    task automatic do_rd(input logic [7:0] a);
        int n, w;
        n = 0;
        w = 0;
        req_addr = a;
        rd_req = 1'b1;
        while (w < 4 && n < 30) begin
            @(negedge mclk);
            n++;
            if (rd_taken === 1'b1) rd_req = 1'b0;
            if (lnk.rdata_oe === 1'b1) begin
                `CHK(lnk.rdata, mdl[{a, 2'(w)}])
                w++;
            end
        end
        rd_req = 1'b0;
        `CHK(w, 4)
    endtask : do_rd

    task automatic idle();
        int n;
        n = 0;
        while ((busy !== 1'b0 || wr_busy !== 1'b0 || rd_busy !== 1'b0) && n < 30) begin
            @(negedge mclk);
            n++;
        end
        `CHK(wr_busy, 1'b0)
    endtask : idle

    initial begin
        rst = 1'b1;
        wr_req = 1'b0;
        rd_req = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        req_en_n = '1;
        tag = 8'h5a;
        err_total = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        `CHK(bws_lane_mask(BWS_ORG_X8, 4'he), 36'h00000000f)
        `CHK(bws_lane_mask(BWS_ORG_X8, 4'hd), 36'h0000000f0)
        `CHK(bws_lane_mask(BWS_ORG_X9, 4'he), 36'h0000001ff)
        `CHK(bws_lane_mask(BWS_ORG_X18, 4'hd), 36'h00003fe00)
        do_wr(8'h10, 16'h0000);
        do_wr(8'h11, 16'h0000);
        idle();
        do_rd(8'h10);
        do_wr(8'h10, 16'h7bde);
        do_rd(8'h11);
        idle();
        do_rd(8'h10);
        do_wr(8'h11, 16'h5a0f);
        idle();
        do_rd(8'h11);
        do_rd(8'h10);
        idle();
        end_sim();
    end
endmodule : burst4_byte_write_sequencer_tb
`default_nettype wire
